// >>> rtl/ipc_defines.svh
// Offsets, field positions, reset values and masks of the interrupt priority block.
`ifndef IPC_DEFINES_SVH
`define IPC_DEFINES_SVH
`define IPC_OFF_PRIO_ONE   8'h00
`define IPC_OFF_PRIO_TWO   8'h04
`define IPC_OFF_PRIO_THREE 8'h08
`define IPC_OFF_RESET_CTRL 8'h0C
`define IPC_OFF_CTRL_ONE   8'h10
`define IPC_OFF_CTRL_TWO   8'h14
`define IPC_OFF_CTRL_THREE 8'h18
`define IPC_OFF_T0_COUNT   8'h1C
`define IPC_OFF_T0_CONFIG  8'h20
`define IPC_RST_PRIO_ONE   8'hFF
`define IPC_RST_PRIO_TWO   8'hCB
`define IPC_RST_PRIO_THREE 8'hFF
`define IPC_RST_RESET_CTRL 8'h1C
`define IPC_RST_CTRL_ONE   8'h00
`define IPC_RST_CTRL_TWO   8'h7F
`define IPC_RST_CTRL_THREE 8'hC0
`define IPC_MASK_PRIO_TWO  8'hCB
`define IPC_MASK_RESET_CTRL 8'h9F
`define IPC_MASK_CTRL_TWO  8'h7F
`define IPC_RC_PRIO_EN     7
`define IPC_RC_RESET_INSTR 4
`define IPC_RC_WDT_TIMEOUT 3
`define IPC_RC_POWER_DOWN  2
`define IPC_RC_POWER_ON    1
`define IPC_RC_BROWNOUT    0
`define IPC_C1_GLOBAL_EN   7
`define IPC_C1_PERIPH_EN   6
`define IPC_C1_T0_EN       5
`define IPC_C1_EXT0_EN     4
`define IPC_C1_PCHG_EN     3
`define IPC_C1_EXT0_FLAG   2
`define IPC_C1_T0_FLAG     1
`define IPC_C1_PCHG_FLAG   0
`define IPC_C2_EDGE_TOP    6
`define IPC_C2_T0_PRIO     2
`define IPC_C2_EXT3_PRIO   1
`define IPC_C2_PCHG_PRIO   0
`define IPC_C3_EXT2_PRIO   7
`define IPC_C3_EXT1_PRIO   6
`define IPC_C3_EN_LSB      3
`define IPC_C3_FLAG_LSB    0
`define IPC_T0_ON          0
`define IPC_T0_WIDE        1
`endif

// >>> rtl/ipc_pkg.sv
// Types shared by the interrupt priority block and its surroundings.
package ipc_pkg;
	// Core context copied into the fast return stack on interrupt entry.
	typedef struct packed {
		logic [7:0] working_register;
		logic [7:0] status;
		logic [7:0] bank_select_register;
	} ipc_ctx_type;
	// Address phase held over into the data phase.
	typedef struct packed {
		logic [7:0] addr;
		logic       write;
	} ipc_req_type;
	// One-hot bus slave states.
	typedef enum logic [2:0] {
		BUS_IDLE  = 3'b001,
		BUS_WRITE = 3'b010,
		BUS_READ  = 3'b100
	} ipc_bus_state_type;
endpackage

// >>> rtl/ipc_top.sv
// Interrupt priority, external pin, timer-0, port-change and context logic with AHB-Lite access.
//
// Added by the designer: the AHB-Lite register port and the address map.
`include "ipc_defines.svh"

// Behaviour
// - Priority bit 1 high level, 0 low.
// - Second priority register bits 5,4,2 read zero.
// - Bit 7 enables two levels, else single-level.
// - Reset-cause flags in bits 4 to 0.
// - Pin edge polarity chosen by edge-select bit.
// - Valid pin edge sets that pin's flag.
// - Cleared pin enable blocks interrupt, flag still sets.
// - Enabled pin wakes core from power-managed mode.
// - Wake branches to vector only with global enable.
// - Pins 1,2,3 priorities from dedicated control bits.
// - Pin zero always high priority.
// - 8-bit timer rollover FF to 00 sets flag.
// - 16-bit timer rollover FFFF to 0000 sets flag.
// - Timer interrupt enable and priority bits.
// - Change on port pins 7:4 sets flag.
// - Port-change enable and priority bits.
// - Entry pushes return address, copies context.
// - Source priorities matter only with levels enabled.
// - Single-level mode needs peripheral enable for peripherals.
module ipc_top
	import ipc_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	input  wire logic [3:0]  ext_pin_in,
	input  wire logic [3:0]  port_b_high_in,
	input  wire logic        timer_tick_in,
	input  wire logic [23:0] periph_req_in,
	input  wire logic        sleep_in,
	input  wire logic        reset_instr_in,
	input  wire logic        wdt_timeout_in,
	input  wire logic        wdt_clear_in,
	input  wire logic        power_on_event_in,
	input  wire logic        brownout_event_in,
	input  wire logic        irq_entry_in,
	input  wire logic [20:0] return_pc_in,
	input  wire ipc_ctx_type core_ctx_in,
	output logic             irq_high_out,
	output logic             irq_low_out,
	output logic             wake_out,
	output logic             wake_vector_out,
	output logic             stack_push_out,
	output logic      [20:0] stack_pc_out,
	output ipc_ctx_type      fast_ctx_out
);

	// Register offset match, shared by the write strobes and the read mux.
	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
		reg_hit = (a == off);
	endfunction

	ipc_bus_state_type bus_state_q;
	ipc_req_type       req_q;
	logic [7:0]  prio_one_q;
	logic [7:0]  prio_two_q;
	logic [7:0]  prio_three_q;
	logic [7:0]  reset_ctrl_q;
	logic [7:0]  ctrl_one_q;
	logic [7:0]  ctrl_two_q;
	logic [7:0]  ctrl_three_q;
	logic [15:0] t0_count_q;
	logic [1:0]  t0_config_q;
	logic [3:0]  ext_s1_q;
	logic [3:0]  ext_s2_q;
	logic [3:0]  ext_s3_q;
	logic [3:0]  pb_s1_q;
	logic [3:0]  pb_s2_q;
	logic [3:0]  pb_s3_q;
	logic [3:0]  sleep_en_q;
	logic        sleep_prev_q;
	logic        bus_accept;
	logic        wr_now;
	logic [7:0]  wr_data;
	logic [3:0]  ext_set;
	logic        pb_change;
	logic        t0_wrap8;
	logic        t0_wrap16;
	logic [3:0]  ext_en;
	logic [3:0]  ext_flag;
	logic [3:0]  ext_prio;
	logic [23:0] prio_all;
	logic [23:0] periph_live;
	logic        t0_act;
	logic        pchg_act;
	logic        core_hi;
	logic        core_lo;
	logic        per_hi;
	logic        per_lo;
	logic        levels_on;
	logic        irq_high_d;
	logic        irq_low_d;
	logic        wake_cond;
	logic [31:0] rd_mux;

	// Address phase is taken only when the bus as a whole is ready.
	assign bus_accept = hsel_in && htrans_in[1] && hready_in;
	assign wr_now     = (bus_state_q == BUS_WRITE);
	assign wr_data    = hwdata_in[7:0];

	// Bus slave: writes finish with no wait, reads add one wait so data is registered.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			bus_state_q   <= BUS_IDLE;
			req_q         <= '0;
			hreadyout_out <= 1'b1;
			hrdata_out    <= 32'h0000_0000;
		end else begin
			case (bus_state_q)
				BUS_IDLE, BUS_WRITE: begin
					if (bus_accept) begin
						req_q         <= '{addr: haddr_in[7:0], write: hwrite_in};
						bus_state_q   <= hwrite_in ? BUS_WRITE : BUS_READ;
						hreadyout_out <= hwrite_in;
					end else begin
						bus_state_q <= BUS_IDLE;
					end
				end
				BUS_READ: begin
					hrdata_out    <= rd_mux;
					hreadyout_out <= 1'b1;
					bus_state_q   <= BUS_IDLE;
				end
				default: begin
					bus_state_q   <= BUS_IDLE;
					hreadyout_out <= 1'b1;
				end
			endcase
		end
	end

	// The slave never signals an error; unmapped reads return zero.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			hresp_out <= 1'b0;
		end else begin
			hresp_out <= 1'b0;
		end
	end

	// Read mux; the second priority register is masked again here, other unimplemented bits at their source registers.
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (reg_hit(req_q.addr, `IPC_OFF_PRIO_ONE))
			rd_mux[7:0] = prio_one_q;
		if (reg_hit(req_q.addr, `IPC_OFF_PRIO_TWO))
			rd_mux[7:0] = prio_two_q & `IPC_MASK_PRIO_TWO;
		if (reg_hit(req_q.addr, `IPC_OFF_PRIO_THREE))
			rd_mux[7:0] = prio_three_q;
		if (reg_hit(req_q.addr, `IPC_OFF_RESET_CTRL))
			rd_mux[7:0] = reset_ctrl_q;
		if (reg_hit(req_q.addr, `IPC_OFF_CTRL_ONE))
			rd_mux[7:0] = ctrl_one_q;
		if (reg_hit(req_q.addr, `IPC_OFF_CTRL_TWO))
			rd_mux[7:0] = ctrl_two_q;
		if (reg_hit(req_q.addr, `IPC_OFF_CTRL_THREE))
			rd_mux[7:0] = ctrl_three_q;
		if (reg_hit(req_q.addr, `IPC_OFF_T0_COUNT))
			rd_mux[15:0] = t0_count_q;
		if (reg_hit(req_q.addr, `IPC_OFF_T0_CONFIG))
			rd_mux[1:0] = t0_config_q;
	end

	// Peripheral priority registers; unimplemented bits of the second never store.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			prio_one_q   <= `IPC_RST_PRIO_ONE;
			prio_two_q   <= `IPC_RST_PRIO_TWO;
			prio_three_q <= `IPC_RST_PRIO_THREE;
		end else if (wr_now) begin
			if (reg_hit(req_q.addr, `IPC_OFF_PRIO_ONE))
				prio_one_q <= wr_data;
			if (reg_hit(req_q.addr, `IPC_OFF_PRIO_TWO))
				prio_two_q <= wr_data & `IPC_MASK_PRIO_TWO;
			if (reg_hit(req_q.addr, `IPC_OFF_PRIO_THREE))
				prio_three_q <= wr_data;
		end
	end

	// Reset-cause flags: a hardware event clears its flag and beats a software write.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			reset_ctrl_q <= `IPC_RST_RESET_CTRL;
		end else begin
			if (wr_now && reg_hit(req_q.addr, `IPC_OFF_RESET_CTRL)) begin
				reset_ctrl_q[`IPC_RC_PRIO_EN]     <= wr_data[`IPC_RC_PRIO_EN];
				reset_ctrl_q[`IPC_RC_RESET_INSTR] <= wr_data[`IPC_RC_RESET_INSTR];
				reset_ctrl_q[`IPC_RC_POWER_ON]    <= wr_data[`IPC_RC_POWER_ON];
				reset_ctrl_q[`IPC_RC_BROWNOUT]    <= wr_data[`IPC_RC_BROWNOUT];
			end
			if (reset_instr_in)
				reset_ctrl_q[`IPC_RC_RESET_INSTR] <= 1'b0;
			if (power_on_event_in)
				reset_ctrl_q[`IPC_RC_POWER_ON] <= 1'b0;
			if (brownout_event_in)
				reset_ctrl_q[`IPC_RC_BROWNOUT] <= 1'b0;
			// Time-out and power-down are read only; a watchdog clear sets both.
			if (wdt_clear_in) begin
				reset_ctrl_q[`IPC_RC_WDT_TIMEOUT] <= 1'b1;
				reset_ctrl_q[`IPC_RC_POWER_DOWN]  <= 1'b1;
			end
			if (wdt_timeout_in)
				reset_ctrl_q[`IPC_RC_WDT_TIMEOUT] <= 1'b0;
			if (sleep_in && !sleep_prev_q)
				reset_ctrl_q[`IPC_RC_POWER_DOWN] <= 1'b0;
		end
	end

	// Pins come from outside the clock domain: two flops, then a third for edges.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ext_s1_q <= 4'h0;
			ext_s2_q <= 4'h0;
			ext_s3_q <= 4'h0;
			pb_s1_q  <= 4'h0;
			pb_s2_q  <= 4'h0;
			pb_s3_q  <= 4'h0;
		end else begin
			ext_s1_q <= ext_pin_in;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			pb_s1_q  <= port_b_high_in;
			pb_s2_q  <= pb_s1_q;
			pb_s3_q  <= pb_s2_q;
		end
	end

	// A pin edge counts only if its new level matches the selected polarity.
	for (genvar i = 0; i < 4; i++) begin : g_edge
		assign ext_set[i] = (ext_s2_q[i] != ext_s3_q[i]) &&
			(ext_s2_q[i] == ctrl_two_q[`IPC_C2_EDGE_TOP - i]);
	end
	// Reset values are zero in both stages, so a high pin at reset sets the flag once.
	assign pb_change = |(pb_s2_q ^ pb_s3_q);

	// Timer-0 rollover detection in both widths.
	assign t0_wrap8  = t0_config_q[`IPC_T0_ON] && timer_tick_in &&
		!t0_config_q[`IPC_T0_WIDE] && (t0_count_q[7:0] == 8'hFF);
	assign t0_wrap16 = t0_config_q[`IPC_T0_ON] && timer_tick_in &&
		t0_config_q[`IPC_T0_WIDE] && (t0_count_q == 16'hFFFF);

	// Timer-0 counter; in 8-bit mode the high byte is left alone.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			t0_count_q  <= 16'h0000;
			t0_config_q <= 2'h0;
		end else begin
			if (wr_now && reg_hit(req_q.addr, `IPC_OFF_T0_CONFIG))
				t0_config_q <= hwdata_in[1:0];
			if (wr_now && reg_hit(req_q.addr, `IPC_OFF_T0_COUNT))
				t0_count_q <= hwdata_in[15:0];
			else if (t0_config_q[`IPC_T0_ON] && timer_tick_in) begin
				if (t0_config_q[`IPC_T0_WIDE])
					t0_count_q <= t0_count_q + 16'h0001;
				else
					t0_count_q[7:0] <= t0_count_q[7:0] + 8'h01;
			end
		end
	end

	// Control register one; hardware flag sets win over a software clear.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ctrl_one_q <= `IPC_RST_CTRL_ONE;
		end else begin
			if (wr_now && reg_hit(req_q.addr, `IPC_OFF_CTRL_ONE))
				ctrl_one_q <= wr_data;
			if (ext_set[0])
				ctrl_one_q[`IPC_C1_EXT0_FLAG] <= 1'b1;
			if (t0_wrap8 || t0_wrap16)
				ctrl_one_q[`IPC_C1_T0_FLAG] <= 1'b1;
			if (pb_change)
				ctrl_one_q[`IPC_C1_PCHG_FLAG] <= 1'b1;
		end
	end

	// Control register two holds edge selects and three priorities.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ctrl_two_q <= `IPC_RST_CTRL_TWO;
		end else if (wr_now && reg_hit(req_q.addr, `IPC_OFF_CTRL_TWO)) begin
			ctrl_two_q <= wr_data & `IPC_MASK_CTRL_TWO;
		end
	end

	// Control register three: pin 1 to 3 enables, flags and two priorities.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ctrl_three_q <= `IPC_RST_CTRL_THREE;
		end else begin
			if (wr_now && reg_hit(req_q.addr, `IPC_OFF_CTRL_THREE))
				ctrl_three_q <= wr_data;
			for (int k = 1; k < 4; k++) begin
				if (ext_set[k])
					ctrl_three_q[`IPC_C3_FLAG_LSB + k - 1] <= 1'b1;
			end
		end
	end

	// Gather per-source enables, flags and priorities.
	assign ext_en   = {ctrl_three_q[`IPC_C3_EN_LSB +: 3], ctrl_one_q[`IPC_C1_EXT0_EN]};
	assign ext_flag = {ctrl_three_q[`IPC_C3_FLAG_LSB +: 3], ctrl_one_q[`IPC_C1_EXT0_FLAG]};
	assign ext_prio = {ctrl_two_q[`IPC_C2_EXT3_PRIO], ctrl_three_q[`IPC_C3_EXT2_PRIO],
		ctrl_three_q[`IPC_C3_EXT1_PRIO], 1'b1};
	assign t0_act   = ctrl_one_q[`IPC_C1_T0_EN] && ctrl_one_q[`IPC_C1_T0_FLAG];
	assign pchg_act = ctrl_one_q[`IPC_C1_PCHG_EN] && ctrl_one_q[`IPC_C1_PCHG_FLAG];
	assign prio_all = {prio_three_q, prio_two_q & `IPC_MASK_PRIO_TWO, prio_one_q};
	// Requests on unimplemented slots of the second register are dropped.
	assign periph_live = periph_req_in & {8'hFF, `IPC_MASK_PRIO_TWO, 8'hFF};
	assign levels_on   = reset_ctrl_q[`IPC_RC_PRIO_EN];

	// Split live requests into the two levels; a disabled pin only leaves its flag.
	always_comb begin
		core_hi = (|(ext_en & ext_flag & ext_prio)) ||
			(t0_act && ctrl_two_q[`IPC_C2_T0_PRIO]) ||
			(pchg_act && ctrl_two_q[`IPC_C2_PCHG_PRIO]);
		core_lo = (|(ext_en & ext_flag & ~ext_prio)) ||
			(t0_act && !ctrl_two_q[`IPC_C2_T0_PRIO]) ||
			(pchg_act && !ctrl_two_q[`IPC_C2_PCHG_PRIO]);
		per_hi  = |(periph_live & prio_all);
		per_lo  = |(periph_live & ~prio_all);
		if (levels_on) begin
			// Bit 6 of control one acts as the low-level global enable here.
			irq_high_d = ctrl_one_q[`IPC_C1_GLOBAL_EN] && (core_hi || per_hi);
			irq_low_d  = ctrl_one_q[`IPC_C1_GLOBAL_EN] && ctrl_one_q[`IPC_C1_PERIPH_EN] &&
				(core_lo || per_lo);
		end else begin
			// Single vector; priority bits are ignored entirely.
			irq_high_d = ctrl_one_q[`IPC_C1_GLOBAL_EN] && (core_hi || core_lo ||
				(ctrl_one_q[`IPC_C1_PERIPH_EN] && (per_hi || per_lo)));
			irq_low_d  = 1'b0;
		end
	end

	// Interrupt request outputs, registered.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			irq_high_out <= 1'b0;
			irq_low_out  <= 1'b0;
		end else begin
			irq_high_out <= irq_high_d;
			irq_low_out  <= irq_low_d;
		end
	end

	// Pin enables are frozen on sleep entry so only those set before sleep can wake.
	assign wake_cond = sleep_in && (|(ext_flag & sleep_en_q));

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			sleep_en_q      <= 4'h0;
			sleep_prev_q    <= 1'b0;
			wake_out        <= 1'b0;
			wake_vector_out <= 1'b0;
		end else begin
			sleep_prev_q <= sleep_in;
			if (!sleep_in)
				sleep_en_q <= ext_en;
			wake_out        <= wake_cond && !wake_out;
			wake_vector_out <= wake_cond && !wake_out && ctrl_one_q[`IPC_C1_GLOBAL_EN];
		end
	end

	// Context capture on entry; software-side saving is needed only without fast return.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			stack_push_out <= 1'b0;
			stack_pc_out   <= 21'h00_0000;
			fast_ctx_out   <= '0;
		end else begin
			stack_push_out <= irq_entry_in;
			if (irq_entry_in) begin
				stack_pc_out <= return_pc_in;
				fast_ctx_out <= core_ctx_in;
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	sequence s_read_taken;
		bus_accept && !hwrite_in;
	endsequence
	sequence s_read_wait;
		!hreadyout_out ##1 hreadyout_out;
	endsequence

	bus_read_wait_a: assert property (s_read_taken |=> s_read_wait)
		else $error("read did not complete after exactly one wait");
	prio_two_zero_a: assert property ((prio_two_q & ~`IPC_MASK_PRIO_TWO) == 8'h00)
		else $error("unimplemented priority bits not zero");
	ext_edge_flag_a: assert property (
		(ext_s2_q[1] && !ext_s3_q[1] && ctrl_two_q[`IPC_C2_EDGE_TOP - 1]) |=>
		ctrl_three_q[`IPC_C3_FLAG_LSB]) else $error("rising edge on pin 1 lost");
	wrong_edge_a: assert property (
		($fell(ext_s2_q[0]) && ctrl_two_q[`IPC_C2_EDGE_TOP] && !ctrl_one_q[`IPC_C1_EXT0_FLAG]
		&& !wr_now) |=> !ctrl_one_q[`IPC_C1_EXT0_FLAG]) else $error("wrong edge set flag");
	flag_hold_a: assert property (
		(ctrl_one_q[`IPC_C1_EXT0_FLAG] && !wr_now) |=> ctrl_one_q[`IPC_C1_EXT0_FLAG])
		else $error("pin flag cleared by hardware");
	t0_narrow_a: assert property (t0_config_q == 2'b01 && timer_tick_in && !wr_now &&
		t0_count_q[7:0] == 8'hFF |=> ctrl_one_q[`IPC_C1_T0_FLAG] && t0_count_q[7:0] == 8'h00)
		else $error("8-bit rollover missed");
	t0_wide_a: assert property (t0_config_q == 2'b11 && timer_tick_in && !wr_now &&
		t0_count_q == 16'hFFFF |=> ctrl_one_q[`IPC_C1_T0_FLAG] && t0_count_q == 16'h0000)
		else $error("16-bit rollover missed");
	port_change_a: assert property ($changed(pb_s2_q) |=> ctrl_one_q[`IPC_C1_PCHG_FLAG])
		else $error("port change flag not set");
	pin_zero_high_a: assert property (levels_on && ctrl_one_q[`IPC_C1_GLOBAL_EN] &&
		ctrl_one_q[`IPC_C1_EXT0_EN] && ctrl_one_q[`IPC_C1_EXT0_FLAG] |=> irq_high_out)
		else $error("pin zero not high priority");
	single_level_a: assert property (!levels_on |=> !irq_low_out)
		else $error("low vector used in single-level mode");
	periph_gate_a: assert property (!levels_on && !ctrl_one_q[`IPC_C1_PERIPH_EN] && !core_hi
		&& !core_lo |=> !irq_high_out) else $error("peripheral passed without enable");
	wake_vector_a: assert property (wake_vector_out |-> wake_out &&
		$past(ctrl_one_q[`IPC_C1_GLOBAL_EN])) else $error("vector without global enable");
	ctx_save_a: assert property (irq_entry_in |=> stack_push_out &&
		fast_ctx_out == $past(core_ctx_in) && stack_pc_out == $past(return_pc_in))
		else $error("context not captured on entry");

endmodule

// >>> verification/ipc_top_tb.sv
// Self-checking testbench of the interrupt priority block, driven over AHB-Lite.
`include "ipc_defines.svh"
module ipc_top_tb
	import ipc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_in    = 1'b0;
	logic        reset_in  = 1'b1;
	logic        hsel      = 1'b0;
	logic [31:0] haddr     = 32'h0000_0000;
	logic [1:0]  htrans    = 2'h0;
	logic        hwrite    = 1'b0;
	logic [31:0] hwdata    = 32'h0000_0000;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic [3:0]  ext_pin   = 4'h0;
	logic [3:0]  port_b    = 4'h0;
	logic        tick      = 1'b0;
	logic [23:0] periph    = 24'h00_0000;
	logic        sleep     = 1'b0;
	logic [4:0]  ev        = 5'h00;
	logic        entry     = 1'b0;
	logic [20:0] pc        = 21'h00_0000;
	ipc_ctx_type ctx       = 24'h00_0000;
	logic        irq_high;
	logic        irq_low;
	logic        wake;
	logic        wake_vec;
	logic        push;
	logic [20:0] stack_pc;
	ipc_ctx_type fast_ctx;
	logic        rd_phase  = 1'b0;
	logic [31:0] rd_q[$];
	logic [44:0] ctx_q[$];
	logic [31:0] rnd;
	logic [31:0] rnd2;
	int          mismatches  = 0;
	int          checks_done = 0;
	logic [31:0] rst_tab[10] = '{32'h0000_00FF, 32'h0000_00CB, 32'h0000_00FF, 32'h0000_001C,
		32'h0000_0000, 32'h0000_007F, 32'h0000_00C0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

	ipc_top i_dut (
		.clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.ext_pin_in(ext_pin), .port_b_high_in(port_b), .timer_tick_in(tick),
		.periph_req_in(periph), .sleep_in(sleep), .reset_instr_in(ev[4]),
		.wdt_timeout_in(ev[3]), .wdt_clear_in(ev[2]), .power_on_event_in(ev[1]),
		.brownout_event_in(ev[0]), .irq_entry_in(entry), .return_pc_in(pc),
		.core_ctx_in(ctx), .irq_high_out(irq_high), .irq_low_out(irq_low),
		.wake_out(wake), .wake_vector_out(wake_vec), .stack_push_out(push),
		.stack_pc_out(stack_pc), .fast_ctx_out(fast_ctx)
	);

	// The clock toggles every half period of 5 ns.
	initial begin
		forever #5 clk_in = ~clk_in;
	end

	task automatic stop_test();
		if (rd_q.size() != 0 || ctx_q.size() != 0) mismatches++;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [44:0] e, input logic [44:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One single transfer; the master never assumes the wait count and holds until hready.
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk_in); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_in); while (hready !== 1'b1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask

	// The expected word is noted first, the monitor compares it when the data phase ends.
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		bus(a, 1'b0, 32'h0000_0000);
	endtask

	task automatic w(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	task automatic irq(input logic h, input logic l);
		check("irq high", {44'h0, h}, {44'h0, irq_high});
		check("irq low", {44'h0, l}, {44'h0, irq_low});
	endtask

	task automatic pulse(input logic [4:0] m);
		ev <= m;
		@(posedge clk_in);
		ev <= 5'h00;
	endtask

	// Waits a bounded time for the wake pulse, then checks its vector qualifier.
	task automatic wake_chk(input logic v);
		int n;
		n = 0;
		while (wake !== 1'b1 && n < 12) begin
			@(posedge clk_in);
			n++;
		end
		check("wake", 45'h1, {44'h0, wake});
		check("wake vector", {44'h0, v}, {44'h0, wake_vec});
	endtask

	// Results are taken at the edge where they stand and matched to the oldest note.
	always @(posedge clk_in) begin
		if (rd_phase && hready === 1'b1) begin
			if (rd_q.size() > 0) check("read data", {13'h0, rd_q.pop_front()}, {13'h0, hrdata});
			check("response", 45'h0, {44'h0, hresp});
		end
		if (push === 1'b1 && ctx_q.size() > 0) begin
			check("saved context", ctx_q.pop_front(), {stack_pc, fast_ctx});
		end
		if (hready === 1'b1) rd_phase <= hsel && htrans[1] && !hwrite;
	end

	// The whole run needs a few hundred cycles, so this limit only trips on a hang.
	initial begin
		#100us;
		mismatches++;
		stop_test();
	end

	initial begin
		void'($urandom(12177));
		w(5);
		reset_in <= 1'b0;
		for (int i = 0; i < 10; i++) rd(8'(4 * i), rst_tab[i]);
		wr(`IPC_OFF_PRIO_TWO, 32'hFFFF_FFFF);
		rd(`IPC_OFF_PRIO_TWO, 32'h0000_00CB);
		rnd = $urandom;
		wr(`IPC_OFF_PRIO_ONE, rnd);
		rd(`IPC_OFF_PRIO_ONE, {24'h00_0000, rnd[7:0]});
		wr(`IPC_OFF_RESET_CTRL, 32'h0000_00FF);
		rd(`IPC_OFF_RESET_CTRL, 32'h0000_009F);
		pulse(5'h1B);
		rd(`IPC_OFF_RESET_CTRL, 32'h0000_0084);
		pulse(5'h04);
		rd(`IPC_OFF_RESET_CTRL, 32'h0000_008C);
		// Single-level mode ignores the low priority bit and needs the peripheral enable.
		wr(`IPC_OFF_RESET_CTRL, 32'h0000_0000);
		wr(`IPC_OFF_PRIO_ONE, 32'h0000_0000);
		periph <= 24'h00_0001;
		wr(`IPC_OFF_CTRL_ONE, 32'h0000_0080);
		w(2);
		irq(1'b0, 1'b0);
		wr(`IPC_OFF_CTRL_ONE, 32'h0000_00C0);
		w(2);
		irq(1'b1, 1'b0);
		wr(`IPC_OFF_RESET_CTRL, 32'h0000_0080);
		w(2);
		irq(1'b0, 1'b1);
		wr(`IPC_OFF_PRIO_ONE, 32'h0000_0001);
		w(2);
		irq(1'b1, 1'b0);
		periph <= 24'h00_0000;
		// Pin zero on a rising edge; the falling edge afterwards must not touch the flag.
		wr(`IPC_OFF_CTRL_ONE, 32'h0000_00D0);
		ext_pin[0] <= 1'b1;
		w(6);
		irq(1'b1, 1'b0);
		rd(`IPC_OFF_CTRL_ONE, 32'h0000_00D4);
		ext_pin[0] <= 1'b0;
		w(6);
		rd(`IPC_OFF_CTRL_ONE, 32'h0000_00D4);
		wr(`IPC_OFF_CTRL_ONE, 32'h0000_00C0);
		w(2);
		irq(1'b0, 1'b0);
		// Pin one on falling edges while its enable is off, then both priority levels.
		wr(`IPC_OFF_CTRL_TWO, 32'h0000_0000);
		ext_pin[1] <= 1'b1;
		w(6);
		rd(`IPC_OFF_CTRL_THREE, 32'h0000_00C0);
		ext_pin[1] <= 1'b0;
		w(6);
		rd(`IPC_OFF_CTRL_THREE, 32'h0000_00C1);
		irq(1'b0, 1'b0);
		wr(`IPC_OFF_CTRL_THREE, 32'h0000_00C9);
		w(2);
		irq(1'b1, 1'b0);
		wr(`IPC_OFF_CTRL_THREE, 32'h0000_0089);
		w(2);
		irq(1'b0, 1'b1);
		wr(`IPC_OFF_CTRL_THREE, 32'h0000_0000);
		// Timer in 8-bit mode rolls FF to 00 after two ticks from FE.
		wr(`IPC_OFF_T0_COUNT, 32'h0000_00FE);
		wr(`IPC_OFF_T0_CONFIG, 32'h0000_0001);
		wr(`IPC_OFF_CTRL_ONE, 32'h0000_00E0);
		tick <= 1'b1;
		w(2);
		tick <= 1'b0;
		w(3);
		irq(1'b0, 1'b1);
		rd(`IPC_OFF_CTRL_ONE, 32'h0000_00E2);
		rd(`IPC_OFF_T0_COUNT, 32'h0000_0000);
		// In 16-bit mode only the rollover of the whole pair counts.
		wr(`IPC_OFF_CTRL_ONE, 32'h0000_00E0);
		wr(`IPC_OFF_T0_CONFIG, 32'h0000_0003);
		wr(`IPC_OFF_T0_COUNT, 32'h0000_00FF);
		tick <= 1'b1;
		w(1);
		tick <= 1'b0;
		w(3);
		rd(`IPC_OFF_T0_COUNT, 32'h0000_0100);
		rd(`IPC_OFF_CTRL_ONE, 32'h0000_00E0);
		wr(`IPC_OFF_T0_COUNT, 32'h0000_FFFF);
		tick <= 1'b1;
		w(1);
		tick <= 1'b0;
		w(3);
		rd(`IPC_OFF_CTRL_ONE, 32'h0000_00E2);
		// Any change on the upper port pins sets the change flag.
		wr(`IPC_OFF_CTRL_ONE, 32'h0000_00C8);
		wr(`IPC_OFF_CTRL_TWO, 32'h0000_0001);
		port_b <= 4'($urandom_range(15, 1));
		w(6);
		irq(1'b1, 1'b0);
		rd(`IPC_OFF_CTRL_ONE, 32'h0000_00C9);
		// Interrupt entry captures a random return address and context.
		rnd = $urandom;
		rnd2 = $urandom;
		ctx_q.push_back({rnd[20:0], rnd2[23:0]});
		pc <= rnd[20:0];
		ctx <= rnd2[23:0];
		entry <= 1'b1;
		w(1);
		entry <= 1'b0;
		w(3);
		// Wake from sleep by pin zero, first without and then with the global enable.
		wr(`IPC_OFF_CTRL_TWO, 32'h0000_0079);
		wr(`IPC_OFF_CTRL_ONE, 32'h0000_0010);
		// The enable must stand a cycle before sleep starts, or it is not frozen in.
		w(1);
		sleep <= 1'b1;
		w(3);
		ext_pin <= 4'h3;
		wake_chk(1'b0);
		sleep <= 1'b0;
		ext_pin <= 4'h0;
		wr(`IPC_OFF_CTRL_ONE, 32'h0000_0090);
		rd(`IPC_OFF_CTRL_THREE, 32'h0000_0001);
		sleep <= 1'b1;
		w(3);
		ext_pin[0] <= 1'b1;
		wake_chk(1'b1);
		w(4);
		stop_test();
	end
endmodule
